// [design/ppcfg_cfg.svh]
// Constants for the parallel port setup register block
`ifndef PPCFG_CFG_SVH
`define PPCFG_CFG_SVH
`define PPCFG_IDX_SETUP     8'hF0
`define PPCFG_IDX_ACTIVATE  8'h30
`define PPCFG_SETUP_RESET   8'hF2
`define PPCFG_SETUP_WMASK   8'hF7
`define PPCFG_MODE_MSB      7
`define PPCFG_MODE_LSB      5
`define PPCFG_EXT_BIT       4
`define PPCFG_RSV_BIT       3
`define PPCFG_REFL_BIT      2
`define PPCFG_PWR_BIT       1
`define PPCFG_TRI_BIT       0
`define PPCFG_EPPVER_BIT    4
`define PPCFG_EXT_LO        11'h403
`define PPCFG_EXT_HI        11'h405
`define PPCFG_STAT_FIX_LOW  4'h9
`define PPCFG_STAT_FIX_HIGH 4'hF
`endif

// [design/ppcfg_pkg.sv]
// Types for the parallel port setup register block
package ppcfg_pkg;
   typedef enum logic [2:0] {
      PPCFG_SPP_COMPAT = 3'h0,
      PPCFG_SPP_EXT    = 3'h1,
      PPCFG_EPP17      = 3'h2,
      PPCFG_EPP19      = 3'h3,
      PPCFG_ECP        = 3'h4,
      PPCFG_RSV5       = 3'h5,
      PPCFG_RSV6       = 3'h6,
      PPCFG_ECP_EPP    = 3'h7
   } ppcfg_mode_t;
endpackage

// [design/ppcfg_decode.sv]
// Mode decoder for the parallel port setup register
`timescale 1ns/1ps
`include "ppcfg_cfg.svh"
module ppcfg_decode (
   // Setup inputs
   input  wire logic [2:0] i_mode,
   input  wire logic       i_ecp_mode4,
   input  wire logic       i_sw_dir_in,
   input  wire logic       i_ctl2_eppver,
   // Decoded mode
   output logic            o_data_out,
   output logic            o_epp_en,
   output logic            o_epp19,
   output logic            o_ecp_en,
   output logic            o_reserved
);
   ppcfg_pkg::ppcfg_mode_t m;
   assign m = ppcfg_pkg::ppcfg_mode_t'(i_mode);
   always_comb begin
      o_data_out = 1'b1;
      o_epp_en   = 1'b0;
      o_epp19    = 1'b0;
      o_ecp_en   = 1'b0;
      o_reserved = 1'b0;
      case (m)
         ppcfg_pkg::PPCFG_SPP_COMPAT: o_data_out = 1'b1;
         ppcfg_pkg::PPCFG_SPP_EXT:    o_data_out = ~i_sw_dir_in;
         ppcfg_pkg::PPCFG_EPP17: begin
            o_epp_en = 1'b1;
         end
         ppcfg_pkg::PPCFG_EPP19: begin
            o_epp_en = 1'b1;
            o_epp19  = 1'b1;
         end
         ppcfg_pkg::PPCFG_ECP: begin
            o_ecp_en   = 1'b1;
            o_data_out = ~i_sw_dir_in;
         end
         ppcfg_pkg::PPCFG_ECP_EPP: begin
            o_ecp_en   = 1'b1;
            o_data_out = ~i_sw_dir_in;
            o_epp_en   = i_ecp_mode4;
            o_epp19    = i_ecp_mode4 & i_ctl2_eppver;
         end
         default: o_reserved = 1'b1;
      endcase
   end
endmodule // ppcfg_decode

// [design/ppcfg_top.sv]
// Parallel port setup register with mode, gating and pin control outputs
// Operation
// - Hardware reset loads the setup register with F2h.
// - Mode 000 is compatible mode; data pins always outputs.
// - Mode 001 is extended compatible; software bit sets data direction.
// - 010 is EPP 1.7, 011 EPP 1.9; ECP mode 4 uses control bit 4.
// - 100 is ECP without EPP, 111 ECP with EPP; 101, 110 reserved.
// - Bit 4 clear ignores accesses to extended registers 403h to 405h.
// - Bit 4 set decodes and serves accesses to 403h to 405h.
// - Disconnected inputs report fixed busy, paper-end, select, acknowledge per bit 2.
// - Bit 1 clear while active gates the port clock; registers kept.
// - Bit 1 set runs the port clock while active; reset state.
// - Bit 0 set and device inactive forces output pins to high impedance.
// - Active comes from activate register qualified by global config bit 0.
`timescale 1ns/1ps
`include "ppcfg_cfg.svh"
module ppcfg_top (
   // Clock and reset
   input  wire logic        I_REF_CLK,
   input  wire logic        I_NRST,
   // Configuration access
   input  wire logic [7:0]  I_CFG_INDEX,
   input  wire logic [7:0]  I_CFG_WDATA,
   input  wire logic        I_CFG_WR,
   input  wire logic        I_CFG_RD,
   output logic      [7:0]  O_CFG_RDATA,
   output logic             O_CFG_HIT,
   // Device activation
   input  wire logic        I_ACTIVATE,
   input  wire logic        I_GLOBAL_CONFIG_ONE_EN,
   // Runtime access from the port engine
   input  wire logic [10:0] I_RT_OFFSET,
   input  wire logic        I_RT_VALID,
   input  wire logic        I_ECP_MODE4,
   input  wire logic        I_SW_DIR_IN,
   input  wire logic        I_SECOND_LEVEL_CONTROL_B_EPPVER,
   // Status inputs from the port pin multiplexer
   input  wire logic        I_PORT_PIN_MULTIPLEXER_DISC,
   input  wire logic        I_BUSY,
   input  wire logic        I_PAPER_END_INPUT,
   input  wire logic        I_PRINTER_SELECT_INPUT,
   input  wire logic        I_ACK,
   // Decoded controls
   output logic      [2:0]  O_MODE,
   output logic             O_DATA_OUT,
   output logic             O_EPP_EN,
   output logic             O_EPP19,
   output logic             O_ECP_EN,
   output logic             O_MODE_RESERVED,
   output logic             O_EXT_SEL,
   output logic             O_PORT_CLK_EN,
   output logic             O_PINS_HIZ,
   output logic             O_ACTIVE,
   output logic      [3:0]  O_EPP_STATUS_REGISTER_IN
);
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic [7:0] setup_reg;
   logic [7:0] setup_next;
   logic [4:0] pin_s1_reg;
   logic [4:0] pin_s2_reg;
   logic       sel_setup;
   logic       active;
   logic       ext_in_range;
   logic       dec_out;
   logic       dec_epp;
   logic       dec_epp19;
   logic       dec_ecp;
   logic       dec_rsv;
   logic [3:0] status_fixed;
   logic [3:0] status_next;

   // Two-stage reset release
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) rst_sync_reg <= 2'h0;
      else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // Pin inputs are asynchronous; the first stage feeds only the second
   always_ff @(posedge I_REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= 5'h00;
         pin_s2_reg <= 5'h00;
      end else begin
         pin_s1_reg <= {I_PORT_PIN_MULTIPLEXER_DISC, I_BUSY, I_PAPER_END_INPUT, I_PRINTER_SELECT_INPUT, I_ACK};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign sel_setup  = (I_CFG_INDEX == `PPCFG_IDX_SETUP);
   // Bit 3 is masked on write, so it can never read back as one
   assign setup_next = (I_CFG_WR && sel_setup) ? (I_CFG_WDATA & `PPCFG_SETUP_WMASK) : setup_reg;
   // Active needs both the activate bit and the global enable
   assign active     = I_ACTIVATE & I_GLOBAL_CONFIG_ONE_EN;
   // Window gate is registered; the port engine sees it one cycle after the offset
   assign ext_in_range = I_RT_VALID && (I_RT_OFFSET >= `PPCFG_EXT_LO) && (I_RT_OFFSET <= `PPCFG_EXT_HI);
   // Fixed values while disconnected: busy, paper end, select, ack
   assign status_fixed = setup_reg[`PPCFG_REFL_BIT] ? `PPCFG_STAT_FIX_HIGH : `PPCFG_STAT_FIX_LOW;
   assign status_next  = pin_s2_reg[4] ? status_fixed : pin_s2_reg[3:0];

   always_ff @(posedge I_REF_CLK or negedge rst_n) begin
      if (!rst_n) setup_reg <= `PPCFG_SETUP_RESET;
      else setup_reg <= setup_next;
   end

   ppcfg_decode u_decode (
      .i_mode        (setup_reg[`PPCFG_MODE_MSB:`PPCFG_MODE_LSB]),
      .i_ecp_mode4   (I_ECP_MODE4),
      .i_sw_dir_in   (I_SW_DIR_IN),
      .i_ctl2_eppver (I_SECOND_LEVEL_CONTROL_B_EPPVER),
      .o_data_out    (dec_out),
      .o_epp_en      (dec_epp),
      .o_epp19       (dec_epp19),
      .o_ecp_en      (dec_ecp),
      .o_reserved    (dec_rsv)
   );

   // All outputs registered, one cycle behind their causes except status, three cycles behind the pins
   always_ff @(posedge I_REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_CFG_RDATA              <= 8'h00;
         O_CFG_HIT                <= 1'b0;
         O_MODE                   <= 3'h0;
         O_DATA_OUT               <= 1'b1;
         O_EPP_EN                 <= 1'b0;
         O_EPP19                  <= 1'b0;
         O_ECP_EN                 <= 1'b0;
         O_MODE_RESERVED          <= 1'b0;
         O_EXT_SEL                <= 1'b0;
         O_PORT_CLK_EN            <= 1'b0;
         O_PINS_HIZ               <= 1'b0;
         O_ACTIVE                 <= 1'b0;
         O_EPP_STATUS_REGISTER_IN <= `PPCFG_STAT_FIX_LOW;
      end else begin
         O_CFG_RDATA              <= (I_CFG_RD && sel_setup) ? setup_reg : 8'h00;
         O_CFG_HIT                <= (I_CFG_RD || I_CFG_WR) && sel_setup;
         O_MODE                   <= setup_reg[`PPCFG_MODE_MSB:`PPCFG_MODE_LSB];
         O_DATA_OUT               <= dec_out;
         O_EPP_EN                 <= dec_epp;
         O_EPP19                  <= dec_epp19;
         O_ECP_EN                 <= dec_ecp;
         O_MODE_RESERVED          <= dec_rsv;
         O_EXT_SEL                <= ext_in_range & setup_reg[`PPCFG_EXT_BIT];
         O_PORT_CLK_EN            <= active & setup_reg[`PPCFG_PWR_BIT];
         O_PINS_HIZ               <= ~active & setup_reg[`PPCFG_TRI_BIT];
         O_ACTIVE                 <= active;
         O_EPP_STATUS_REGISTER_IN <= status_next;
      end
   end

   // Checks; rst_n in an antecedent skips the first edge, where outputs still hold reset values
   a_reset_value: assert property (@(posedge I_REF_CLK) $rose(rst_n) |-> setup_reg == 8'hF2)
      else $error("setup register not F2h after reset");
   a_compat_out: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h0 |=> O_DATA_OUT)
      else $error("compatible mode data not output");
   a_ext_dir: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h1 |=> O_DATA_OUT == ~$past(I_SW_DIR_IN))
      else $error("extended mode direction wrong");
   a_epp_version: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h3 |=> O_EPP_EN && O_EPP19)
      else $error("EPP 1.9 not selected");
   a_epp17_sel: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h2 |=> O_EPP_EN && !O_EPP19 && !O_ECP_EN)
      else $error("EPP 1.7 not selected");
   a_ecp_noepp: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h4 |=> O_ECP_EN && !O_EPP_EN)
      else $error("ECP without EPP wrong");
   a_ecp_mode4: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      rst_n && setup_reg[7:5] == 3'h7 |=> O_ECP_EN && O_EPP_EN == $past(I_ECP_MODE4) &&
         O_EPP19 == ($past(I_ECP_MODE4) & $past(I_SECOND_LEVEL_CONTROL_B_EPPVER)))
      else $error("ECP mode 4 selection wrong");
   a_rsv_mode: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[7:5] == 3'h5 || setup_reg[7:5] == 3'h6 |=> O_MODE_RESERVED && !O_EPP_EN && !O_ECP_EN)
      else $error("reserved mode enables a protocol");
   // Extended window gating
   a_ext_block: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      !setup_reg[4] |=> !O_EXT_SEL)
      else $error("extended register reached while disabled");
   a_ext_serve: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[4] && I_RT_VALID && I_RT_OFFSET == 11'h404 |=> O_EXT_SEL)
      else $error("extended register not served");
   // Status reflection while disconnected
   a_refl_fixed: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      pin_s2_reg[4] && !setup_reg[2] |=> O_EPP_STATUS_REGISTER_IN == 4'h9)
      else $error("reflected inputs wrong");
   a_refl_all_one: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      pin_s2_reg[4] && setup_reg[2] |=> O_EPP_STATUS_REGISTER_IN == 4'hF)
      else $error("reflected inputs not all one");
   // Clock, pin and activation control
   a_clk_gate: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      !setup_reg[1] |=> !O_PORT_CLK_EN)
      else $error("port clock not gated");
   a_clk_run: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[1] && active |=> O_PORT_CLK_EN)
      else $error("port clock not running");
   a_hiz_force: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      setup_reg[0] && !active |=> O_PINS_HIZ)
      else $error("pins not high impedance");
   a_hiz_off: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      !setup_reg[0] |=> !O_PINS_HIZ)
      else $error("pins forced without enable");
   a_active_qual: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      rst_n |=> O_ACTIVE == ($past(I_ACTIVATE) & $past(I_GLOBAL_CONFIG_ONE_EN)))
      else $error("active qualification wrong");
   // Register access
   a_rsv_zero: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      I_CFG_WR && sel_setup |=> setup_reg[3] == 1'b0 ##1 O_CFG_RDATA[3] == 1'b0)
      else $error("reserved bit not zero");
   a_wr_lands: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      I_CFG_WR && sel_setup |=> setup_reg == ($past(I_CFG_WDATA) & 8'hF7))
      else $error("setup write not taken");
   a_read_back: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      I_CFG_RD && sel_setup |=> O_CFG_RDATA == $past(setup_reg))
      else $error("setup read data wrong");
   // Coverage of the main scenarios
   c_write_setup: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) I_CFG_WR && sel_setup);
   c_ecp_epp19: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) O_ECP_EN && O_EPP19);
   c_ext_access: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) O_EXT_SEL);
   c_hiz: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) O_PINS_HIZ);
   c_disconnected: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) pin_s2_reg[4]);
endmodule // ppcfg_top

// [bench/parallel_port_config_register_tb_top.sv]
// Self-checking bench for the parallel port setup register
`timescale 1ns/1ps
module parallel_port_config_register_tb_top;
   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic [7:0]  idx    = 8'h00;
   logic [7:0]  wd     = 8'h00;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic        act    = 1'b0;
   logic        glb    = 1'b0;
   logic [10:0] rt_off = 11'h000;
   logic        rt_v   = 1'b0;
   logic        m4     = 1'b0;
   logic        dir    = 1'b1;
   logic        ver    = 1'b0;
   logic        disc   = 1'b0;
   logic [3:0]  pins   = 4'h5;
   logic [7:0]  rdata;
   logic [3:0]  stat;
   logic [2:0]  mode;
   logic        hit, dout, epp, e19, ecp, rsv, ext, clken, hiz, active;
   int          failures = 0;
   int          n_tests  = 0;
   int          cyc      = 0;
   // Decode table {data_out, epp, epp19, ecp, reserved}; mask hides what is left open
   logic [4:0]  mv [8] = '{5'h10, 5'h00, 5'h08, 5'h0C, 5'h02, 5'h11, 5'h11, 5'h02};
   logic [4:0]  mm [8] = '{5'h1F, 5'h1F, 5'h0F, 5'h0F, 5'h1F, 5'h1F, 5'h1F, 5'h17};

   ppcfg_top DUT (
      .I_REF_CLK(clk), .I_NRST(nrst), .I_CFG_INDEX(idx), .I_CFG_WDATA(wd), .I_CFG_WR(wr),
      .I_CFG_RD(rd), .O_CFG_RDATA(rdata), .O_CFG_HIT(hit), .I_ACTIVATE(act),
      .I_GLOBAL_CONFIG_ONE_EN(glb), .I_RT_OFFSET(rt_off), .I_RT_VALID(rt_v), .I_ECP_MODE4(m4),
      .I_SW_DIR_IN(dir), .I_SECOND_LEVEL_CONTROL_B_EPPVER(ver), .I_PORT_PIN_MULTIPLEXER_DISC(disc),
      .I_BUSY(pins[3]), .I_PAPER_END_INPUT(pins[2]), .I_PRINTER_SELECT_INPUT(pins[1]), .I_ACK(pins[0]),
      .O_MODE(mode), .O_DATA_OUT(dout), .O_EPP_EN(epp), .O_EPP19(e19), .O_ECP_EN(ecp),
      .O_MODE_RESERVED(rsv), .O_EXT_SEL(ext), .O_PORT_CLK_EN(clken), .O_PINS_HIZ(hiz),
      .O_ACTIVE(active), .O_EPP_STATUS_REGISTER_IN(stat));

   always #4 clk = ~clk;

   // Cuts a hang short; the full sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write lands on the next edge; decode follows one edge later
   task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
      idx = i;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      chk("wr_hit", {7'h00, i == 8'hF0}, {7'h00, hit});
      @(negedge clk);
   endtask

   // Read data stands for one cycle after the taking edge
   task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
      idx = i;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("rdata", e, rdata);
      chk("rd_hit", {7'h00, i == 8'hF0}, {7'h00, hit});
      @(negedge clk);
   endtask

   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      cfg_rd(8'hF0, 8'hF2);
      chk("mode", 8'h07, {5'h00, mode});
      chk("ctl", 8'h00, {5'h00, clken, hiz, active});
      for (int m = 0; m < 8; m++) begin
         cfg_wr(8'hF0, {m[2:0], 5'h12});
         chk("mode", {5'h00, m[2:0]}, {5'h00, mode});
         chk("decode", {3'h0, mv[m]}, {3'h0, {dout, epp, e19, ecp, rsv} & mm[m]});
         cfg_rd(8'hF0, {m[2:0], 5'h12});
      end
      m4 = 1'b1;
      ver = 1'b1;
      repeat (2) @(negedge clk);
      chk("epp19", 8'h03, {6'h00, epp, e19});
      ver = 1'b0;
      repeat (2) @(negedge clk);
      chk("epp19", 8'h02, {6'h00, epp, e19});
      cfg_wr(8'hF0, 8'h32);
      dir = 1'b0;
      repeat (2) @(negedge clk);
      chk("dir", 8'h01, {7'h00, dout});
      dir = 1'b1;
      repeat (2) @(negedge clk);
      chk("dir", 8'h00, {7'h00, dout});
      cfg_wr(8'hF0, 8'hFF);
      cfg_rd(8'hF0, 8'hF7);
      cfg_wr(8'h30, 8'h00);
      cfg_rd(8'hF0, 8'hF7);
      cfg_rd(8'h30, 8'h00);
      for (int b = 0; b < 2; b++) begin
         cfg_wr(8'hF0, b ? 8'hF2 : 8'hE2);
         rt_v = 1'b1;
         for (int o = 11'h402; o <= 11'h406; o++) begin
            rt_off = o[10:0];
            @(negedge clk);
            chk("ext", {7'h00, b == 1 && o >= 11'h403 && o <= 11'h405}, {7'h00, ext});
         end
         rt_off = 11'h404;
         rt_v = 1'b0;
         @(negedge clk);
         chk("ext", 8'h00, {7'h00, ext});
      end
      repeat (4) @(negedge clk);
      chk("status", 8'h05, {4'h0, stat});
      disc = 1'b1;
      repeat (4) @(negedge clk);
      chk("status", 8'h09, {4'h0, stat});
      cfg_wr(8'hF0, 8'hF6);
      @(negedge clk);
      chk("status", 8'h0F, {4'h0, stat});
      for (int k = 0; k < 8; k++) begin
         act = k[0];
         glb = k[1];
         cfg_wr(8'hF0, k[2] ? 8'hF3 : 8'hF0);
         repeat (2) @(negedge clk);
         chk("act", {5'h00, &k[1:0], &k[2:0], k[2] & ~&k[1:0]}, {5'h00, active, clken, hiz});
      end
      report_and_stop();
   end
endmodule // parallel_port_config_register_tb_top
